// ### verilog/bap_radio_end.sv
/*
 * radio end of the host pin routing: uart, wake, audio port, clock request.
 * assumes the uart and audio engines sit on the user side on clk_sys.
 */
`timescale 1ns/1ps
`include "bap_consts.svh"
module bap_radio_end #(
	parameter int SLEEP_TIMEOUT_CYC = `BAP_SLEEP_TIMEOUT_CYC
) (
	input wire logic clk_sys,
	input wire logic sys_rst,
	bap_pins_if.radio pins,
	input wire logic route_wr,
	input wire bap_pkg::bap_route_t route_wr_val,
	input wire bap_pkg::bap_audio_role_t audio_role,
	input wire logic uart_tx_bit,
	input wire logic uart_rx_ready,
	output logic uart_rx_bit,
	output logic uart_tx_permit,
	output logic three_wire_mode,
	output bap_pkg::bap_route_t route_now,
	input wire logic host_wake_req,
	output logic dev_wake_seen,
	input wire logic audio_clk_src,
	input wire logic audio_sync_src,
	input wire logic audio_out_bit,
	output logic audio_clk_rx,
	output logic audio_sync_rx,
	output logic audio_in_bit,
	input wire logic bt_clk_need,
	input wire logic wlan_clk_need,
	input wire logic deep_sleep_req,
	output logic deep_sleep_grant,
	output logic low_energy_always_on
);
	import bap_pkg::*;

	localparam int CW = $clog2(SLEEP_TIMEOUT_CYC + 1);
	localparam int NIN = 9;

	// ==========================================
	// elaboration check
	generate
		if (SLEEP_TIMEOUT_CYC < 2) begin : g_bad_timeout
			$error("sleep clock timeout must be at least two cycles");
		end
	endgenerate

	// ==========================================
	// pin input synchronisers
	logic [NIN-1:0] pin_raw;
	logic [NIN-1:0] pin_meta;
	logic [NIN-1:0] pin_s;

	assign pin_raw = {pins.serial_receive_line, pins.serial_clear_to_send_low,
		pins.serial_request_to_send_low, pins.radio_to_host_wake, pins.host_to_radio_wake,
		pins.audio_bit_clock, pins.audio_frame_sync, pins.audio_serial_in,
		pins.sleep_clock_input};

	// flops start at the pin's idle level so no false permit follows reset
	localparam logic [NIN-1:0] PIN_IDLE = {`BAP_LINE_IDLE, `BAP_FLOW_HOLD, `BAP_FLOW_HOLD,
		`BAP_LINE_IDLE, 5'h00};

	genvar gi;
	generate
		for (gi = 0; gi < NIN; gi++) begin : g_sync
			always_ff @(posedge clk_sys) begin
				if (sys_rst) begin
					pin_meta[gi] <= PIN_IDLE[gi];
					pin_s[gi] <= PIN_IDLE[gi];
				end else begin
					pin_meta[gi] <= pin_raw[gi];
					pin_s[gi] <= pin_meta[gi];
				end
			end
		end
	endgenerate

	logic s_rxd, s_cts, s_rts, s_hwake, s_dwake, s_aclk, s_async, s_ain, s_sleep;
	assign {s_rxd, s_cts, s_rts, s_hwake, s_dwake, s_aclk, s_async, s_ain, s_sleep} = pin_s;

	// ==========================================
	// route control
	bap_route_t route, next_route;
	logic alt;

	always_comb begin
		next_route = route;
		if (route_wr) begin
			next_route = route_wr_val;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			route <= BAP_ROUTE_DEFAULT;
		end else begin
			route <= next_route;
		end
	end

	assign alt = (route == BAP_ROUTE_AUDIO);
	assign route_now = route;

	// ==========================================
	// pin drive and user-side receive
	logic master;
	assign master = (audio_role == BAP_AUDIO_MASTER);

	logic txd, cts_o, cts_oe, rts_o, rts_oe, hw_o, hw_oe;
	logic ac_o, ac_oe, as_o, as_oe, aout, creq;
	logic next_txd, next_cts_o, next_cts_oe, next_rts_o, next_rts_oe, next_hw_o, next_hw_oe;
	logic next_ac_o, next_ac_oe, next_as_o, next_as_oe, next_aout, next_creq;
	logic rxb, permit, twm, dws, acr, asr, ainb;
	logic next_rxb, next_permit, next_twm, next_dws, next_acr, next_asr, next_ainb;

	always_comb begin
		next_txd = uart_tx_bit;
		next_rxb = s_rxd;
		next_creq = bt_clk_need | wlan_clk_need;
		next_twm = alt;
		next_cts_o = `BAP_LINE_IDLE;
		next_cts_oe = 1'b0;
		next_ac_o = 1'b0;
		next_ac_oe = 1'b0;
		next_as_o = 1'b0;
		next_as_oe = 1'b0;
		next_aout = 1'b0;
		if (alt) begin
			next_rts_o = audio_clk_src;
			next_rts_oe = master;
			next_cts_o = audio_out_bit;
			next_cts_oe = 1'b1;
			next_hw_o = audio_sync_src;
			next_hw_oe = master;
			// no flow control pins left: transport runs 3-wire
			next_permit = 1'b1;
			next_dws = 1'b0;
			next_acr = master ? audio_clk_src : s_rts;
			next_asr = master ? audio_sync_src : s_hwake;
			next_ainb = s_dwake;
		end else begin
			next_rts_o = ~uart_rx_ready;
			next_rts_oe = 1'b1;
			next_hw_o = host_wake_req;
			next_hw_oe = 1'b1;
			next_ac_o = audio_clk_src;
			next_ac_oe = master;
			next_as_o = audio_sync_src;
			next_as_oe = master;
			next_aout = audio_out_bit;
			next_permit = ~s_cts;
			next_dws = s_dwake;
			next_acr = master ? audio_clk_src : s_aclk;
			next_asr = master ? audio_sync_src : s_async;
			next_ainb = s_ain;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			txd <= `BAP_LINE_IDLE;
			cts_o <= `BAP_LINE_IDLE;
			cts_oe <= 1'b0;
			rts_o <= `BAP_FLOW_HOLD;
			rts_oe <= 1'b1;
			hw_o <= 1'b0;
			hw_oe <= 1'b1;
			ac_o <= 1'b0;
			ac_oe <= 1'b0;
			as_o <= 1'b0;
			as_oe <= 1'b0;
			aout <= 1'b0;
			creq <= 1'b0;
			rxb <= `BAP_LINE_IDLE;
			permit <= 1'b0;
			twm <= 1'b0;
			dws <= 1'b0;
			acr <= 1'b0;
			asr <= 1'b0;
			ainb <= 1'b0;
		end else begin
			txd <= next_txd;
			cts_o <= next_cts_o;
			cts_oe <= next_cts_oe;
			rts_o <= next_rts_o;
			rts_oe <= next_rts_oe;
			hw_o <= next_hw_o;
			hw_oe <= next_hw_oe;
			ac_o <= next_ac_o;
			ac_oe <= next_ac_oe;
			as_o <= next_as_o;
			as_oe <= next_as_oe;
			aout <= next_aout;
			creq <= next_creq;
			rxb <= next_rxb;
			permit <= next_permit;
			twm <= next_twm;
			dws <= next_dws;
			acr <= next_acr;
			asr <= next_asr;
			ainb <= next_ainb;
		end
	end

	assign pins.serial_transmit_line = txd;
	assign pins.cts_dev_o = cts_o;
	assign pins.cts_dev_oe = cts_oe;
	assign pins.rts_dev_o = rts_o;
	assign pins.rts_dev_oe = rts_oe;
	assign pins.hwake_dev_o = hw_o;
	assign pins.hwake_dev_oe = hw_oe;
	assign pins.aclk_dev_o = ac_o;
	assign pins.aclk_dev_oe = ac_oe;
	assign pins.async_dev_o = as_o;
	assign pins.async_dev_oe = as_oe;
	assign pins.audio_serial_out = aout;
	assign pins.clk_request = creq;
	assign uart_rx_bit = rxb;
	assign uart_tx_permit = permit;
	assign three_wire_mode = twm;
	assign dev_wake_seen = dws;
	assign audio_clk_rx = acr;
	assign audio_sync_rx = asr;
	assign audio_in_bit = ainb;

	// ==========================================
	// sleep clock presence
	// a held-low input never toggles, so a missing edge means no clock
	logic [CW-1:0] idle_cnt, next_idle_cnt;
	logic sleep_prev, next_sleep_prev, present, next_present, grant, next_grant;

	always_comb begin
		next_sleep_prev = s_sleep;
		next_idle_cnt = idle_cnt;
		next_present = present;
		if (s_sleep != sleep_prev) begin
			next_idle_cnt = '0;
			next_present = 1'b1;
		end else if (idle_cnt == CW'(SLEEP_TIMEOUT_CYC)) begin
			next_present = 1'b0;
		end else begin
			next_idle_cnt = idle_cnt + CW'(1);
		end
		next_grant = deep_sleep_req & next_present;
	end

	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			idle_cnt <= '0;
			sleep_prev <= 1'b0;
			present <= 1'b0;
			grant <= 1'b0;
		end else begin
			idle_cnt <= next_idle_cnt;
			sleep_prev <= next_sleep_prev;
			present <= next_present;
			grant <= next_grant;
		end
	end

	assign deep_sleep_grant = grant;
	assign low_energy_always_on = ~present;
endmodule

// ### verilog/bap_consts.svh
/*
 * timing counts and reset values shared by both pin-routing ends.
 * assumes a 50 MHz system clock on each end.
 */
`ifndef BAP_CONSTS_SVH
`define BAP_CONSTS_SVH

// ==========================================
// clocking
`define BAP_SYS_CLK_PERIOD_NS 20
`define BAP_SLEEP_CLK_PERIOD_NS 30518
`define BAP_SLEEP_MISS_PERIODS 2
`define BAP_SLEEP_TIMEOUT_CYC \
	((`BAP_SLEEP_CLK_PERIOD_NS * `BAP_SLEEP_MISS_PERIODS) / `BAP_SYS_CLK_PERIOD_NS)

// ==========================================
// reset values and synchroniser depth
`define BAP_ROUTE_RST 1'b0
`define BAP_LINE_IDLE 1'b1
`define BAP_FLOW_HOLD 1'b1
`define BAP_SYNC_STAGES 2

`endif

// ### verilog/bap_pkg.sv
/*
 * types shared by both ends of the pin routing.
 * assumes bap_consts.svh for numeric values.
 */
package bap_pkg;
	// ==========================================
	// pin function selection
	typedef enum logic {
		BAP_ROUTE_DEFAULT,
		BAP_ROUTE_AUDIO
	} bap_route_t;
	// ==========================================
	// who makes the audio clock and frame sync
	typedef enum logic {
		BAP_AUDIO_SLAVE,
		BAP_AUDIO_MASTER
	} bap_audio_role_t;
endpackage

// ### verilog/bap_pins_if.sv
/*
 * host-side pin bundle of the radio, with per-party drive and enable.
 * assumes pull-ups on flow/wake pins and pull-downs on clock pins.
 */
`timescale 1ns/1ps
interface bap_pins_if;
	logic serial_receive_line;
	logic serial_transmit_line;
	logic cts_dev_o, cts_dev_oe, cts_host_o, cts_host_oe;
	logic rts_dev_o, rts_dev_oe, rts_host_o, rts_host_oe;
	logic hwake_dev_o, hwake_dev_oe, hwake_host_o, hwake_host_oe;
	logic host_to_radio_wake;
	logic aclk_dev_o, aclk_dev_oe, aclk_host_o, aclk_host_oe;
	logic async_dev_o, async_dev_oe, async_host_o, async_host_oe;
	logic audio_serial_in;
	logic audio_serial_out;
	logic clk_request;
	logic sleep_clock_input;
	// ==========================================
	// resolved pin levels
	logic serial_clear_to_send_low, serial_request_to_send_low;
	logic radio_to_host_wake, audio_bit_clock, audio_frame_sync;

	function automatic logic bap_pin(input logic d_oe, input logic d_o,
		input logic h_oe, input logic h_o, input logic pull);
		bap_pin = d_oe ? d_o : (h_oe ? h_o : pull);
	endfunction

	assign serial_clear_to_send_low =
		bap_pin(cts_dev_oe, cts_dev_o, cts_host_oe, cts_host_o, 1'b1);
	assign serial_request_to_send_low =
		bap_pin(rts_dev_oe, rts_dev_o, rts_host_oe, rts_host_o, 1'b1);
	assign radio_to_host_wake =
		bap_pin(hwake_dev_oe, hwake_dev_o, hwake_host_oe, hwake_host_o, 1'b1);
	assign audio_bit_clock = bap_pin(aclk_dev_oe, aclk_dev_o, aclk_host_oe, aclk_host_o, 1'b0);
	assign audio_frame_sync =
		bap_pin(async_dev_oe, async_dev_o, async_host_oe, async_host_o, 1'b0);

	modport radio (
		input serial_receive_line, serial_clear_to_send_low, serial_request_to_send_low,
		input radio_to_host_wake, host_to_radio_wake, audio_bit_clock, audio_frame_sync,
		input audio_serial_in, sleep_clock_input,
		output serial_transmit_line, cts_dev_o, cts_dev_oe, rts_dev_o, rts_dev_oe,
		output hwake_dev_o, hwake_dev_oe, aclk_dev_o, aclk_dev_oe, async_dev_o, async_dev_oe,
		output audio_serial_out, clk_request
	);
	modport host (
		input serial_transmit_line, serial_clear_to_send_low, serial_request_to_send_low,
		input radio_to_host_wake, audio_bit_clock, audio_frame_sync, audio_serial_out,
		input clk_request,
		output serial_receive_line, cts_host_o, cts_host_oe, rts_host_o, rts_host_oe,
		output hwake_host_o, hwake_host_oe, host_to_radio_wake, aclk_host_o, aclk_host_oe,
		output async_host_o, async_host_oe, audio_serial_in, sleep_clock_input
	);
endinterface

// ### verilog/bap_host_end.sv
/*
 * host end of the radio pin routing: uart, wake, audio port, sleep clock.
 * assumes host software mirrors the route written into the radio.
 */
`timescale 1ns/1ps
`include "bap_consts.svh"
module bap_host_end (
	input wire logic clk_sys,
	input wire logic sys_rst,
	bap_pins_if.host pins,
	input wire bap_pkg::bap_route_t route_sel,
	input wire bap_pkg::bap_audio_role_t radio_role,
	input wire logic uart_tx_bit,
	input wire logic uart_rx_ready,
	output logic uart_rx_bit,
	output logic uart_tx_permit,
	input wire logic radio_wake_req,
	output logic radio_wake_seen,
	input wire logic audio_clk_src,
	input wire logic audio_sync_src,
	input wire logic audio_out_bit,
	output logic audio_clk_rx,
	output logic audio_sync_rx,
	output logic audio_in_bit,
	input wire logic sleep_clk_en,
	input wire logic sleep_clk_src,
	output logic clk_request_seen
);
	import bap_pkg::*;

	localparam int NIN = 7;

	// ==========================================
	// pin input synchronisers
	logic [NIN-1:0] pin_raw;
	logic [NIN-1:0] pin_meta;
	logic [NIN-1:0] pin_s;

	assign pin_raw = {pins.serial_transmit_line, pins.serial_clear_to_send_low,
		pins.serial_request_to_send_low, pins.radio_to_host_wake, pins.audio_bit_clock,
		pins.audio_frame_sync, pins.audio_serial_out};

	// flops start at the pin's idle level so no false permit follows reset
	localparam logic [NIN-1:0] PIN_IDLE = {`BAP_LINE_IDLE, `BAP_FLOW_HOLD, `BAP_FLOW_HOLD,
		`BAP_LINE_IDLE, 3'h0};

	genvar gi;
	generate
		for (gi = 0; gi < NIN; gi++) begin : g_sync
			always_ff @(posedge clk_sys) begin
				if (sys_rst) begin
					pin_meta[gi] <= PIN_IDLE[gi];
					pin_s[gi] <= PIN_IDLE[gi];
				end else begin
					pin_meta[gi] <= pin_raw[gi];
					pin_s[gi] <= pin_meta[gi];
				end
			end
		end
	endgenerate

	logic s_txd, s_cts, s_rts, s_hwake, s_aclk, s_async, s_aout;
	assign {s_txd, s_cts, s_rts, s_hwake, s_aclk, s_async, s_aout} = pin_s;

	logic alt, hmaster;
	assign alt = (route_sel == BAP_ROUTE_AUDIO);
	assign hmaster = (radio_role == BAP_AUDIO_SLAVE);

	// ==========================================
	// pin drive and user-side receive
	logic [11:0] drv, next_drv;
	logic [6:0] rcv, next_rcv;
	logic creq_meta, creq;

	always_comb begin
		// rxd, cts o/oe, rts o/oe, hw o/oe, dwake, aclk oe, async oe, sleep clk, audio in... packed below
		next_drv = '0;
		next_drv[0] = uart_tx_bit;
		next_drv[10] = sleep_clk_en & sleep_clk_src;
		if (alt) begin
			next_drv[3] = audio_clk_src;
			next_drv[4] = hmaster;
			next_drv[5] = audio_sync_src;
			next_drv[6] = hmaster;
			next_drv[7] = audio_out_bit;
			next_rcv = {s_txd, 1'b1, 1'b0, hmaster ? audio_clk_src : s_rts,
				hmaster ? audio_sync_src : s_hwake, s_cts, 1'b0};
		end else begin
			next_drv[1] = ~uart_rx_ready;
			next_drv[2] = 1'b1;
			next_drv[7] = radio_wake_req;
			next_drv[8] = hmaster;
			next_drv[9] = hmaster;
			next_drv[11] = audio_out_bit;
			next_rcv = {s_txd, ~s_rts, s_hwake, hmaster ? audio_clk_src : s_aclk,
				hmaster ? audio_sync_src : s_async, s_aout, 1'b0};
		end
	end

	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			drv <= 12'h001;
			rcv <= 7'h40;
			creq_meta <= 1'b0;
			creq <= 1'b0;
		end else begin
			drv <= next_drv;
			rcv <= next_rcv;
			creq_meta <= pins.clk_request;
			creq <= creq_meta;
		end
	end

	// dedicated clock and sync pins carry the same source as the routed ones
	assign pins.serial_receive_line = drv[0];
	assign pins.cts_host_o = drv[1];
	assign pins.cts_host_oe = drv[2];
	assign pins.rts_host_o = drv[3];
	assign pins.rts_host_oe = drv[4];
	assign pins.hwake_host_o = drv[5];
	assign pins.hwake_host_oe = drv[6];
	assign pins.host_to_radio_wake = drv[7];
	assign pins.aclk_host_o = audio_clk_rx & drv[8];
	assign pins.aclk_host_oe = drv[8];
	assign pins.async_host_o = audio_sync_rx & drv[9];
	assign pins.async_host_oe = drv[9];
	assign pins.audio_serial_in = drv[11];
	assign pins.sleep_clock_input = drv[10];
	assign {uart_rx_bit, uart_tx_permit, radio_wake_seen, audio_clk_rx, audio_sync_rx,
		audio_in_bit} = rcv[6:1];
	assign clk_request_seen = creq;
endmodule

// ### sim/bap_pins_chk.sv
/* checker for the shared pin bundle of both routing ends.
   assumes tb instantiates it beside the interface. */
`timescale 1ns/1ps
module bap_pins_chk (
	input wire logic clk_sys,
	input wire logic sys_rst,
	input wire logic serial_transmit_line,
	input wire logic clk_request,
	input wire logic audio_serial_out,
	input wire logic cts_dev_oe,
	input wire logic cts_host_oe,
	input wire logic rts_dev_o,
	input wire logic rts_dev_oe,
	input wire logic rts_host_oe,
	input wire logic hwake_dev_oe,
	input wire logic hwake_host_oe,
	input wire logic aclk_dev_oe,
	input wire logic async_dev_oe
);
	// ==========================================
	// settled routes
	default clocking @(posedge clk_sys); endclocking
	default disable iff (sys_rst);
	// role changes may skew one cycle between ends, so wait for stable enables
	sequence alt_settled;
		(cts_dev_oe && $stable(rts_dev_oe) && $stable(rts_host_oe) &&
			$stable(hwake_dev_oe) && $stable(hwake_host_oe)) [*3];
	endsequence
	sequence dflt_settled;
		(!cts_dev_oe && cts_host_oe) [*3];
	endsequence
	// ==========================================
	// assertions
	rst_idle_a: assert property (disable iff (1'b0) sys_rst ##1 sys_rst |->
		serial_transmit_line && !clk_request && !cts_dev_oe && rts_dev_oe && rts_dev_o)
		else $error("pins not idle in reset");
	alt_rts_a: assert property (alt_settled |-> rts_dev_oe != rts_host_oe)
		else $error("bit clock on rts not driven by exactly one end");
	alt_sync_a: assert property (alt_settled |-> hwake_dev_oe != hwake_host_oe)
		else $error("frame sync on wake pin not driven by exactly one end");
	alt_ded_a: assert property (cts_dev_oe |-> !aclk_dev_oe && !async_dev_oe && !audio_serial_out)
		else $error("dedicated audio pins active in alternate route");
	alt_cts_a: assert property (alt_settled |-> !cts_host_oe)
		else $error("host still drives clear-to-send in alternate route");
	dflt_rts_a: assert property (dflt_settled |-> rts_dev_oe && !rts_host_oe)
		else $error("request-to-send not owned by radio");
	dflt_wake_a: assert property (dflt_settled |-> hwake_dev_oe && !hwake_host_oe)
		else $error("host wake pin not owned by radio");
	rts_back_a: assert property ($fell(cts_dev_oe) |-> rts_dev_oe)
		else $error("rts not returned to radio with route");
endmodule

// ### sim/tb.sv
/* self-checking bench joining radio and host ends over the pin bundle.
   assumes the design files compile first. */
`timescale 1ns/1ps
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin err_count++; \
	$display("[FAIL] t=%0t got %h exp %h", $time, a, b); end end
module tb;
	import bap_pkg::*;
	// ==========================================
	// stimulus and observation
	logic clk_sys = 1'b0, sys_rst = 1'b1, route_wr = 1'b0;
	int err_count = 0, cmp_count = 0, cyc = 0;
	bap_route_t route_val = BAP_ROUTE_DEFAULT, h_route = BAP_ROUTE_DEFAULT, r_route;
	bap_audio_role_t r_role = BAP_AUDIO_MASTER, h_role = BAP_AUDIO_MASTER;
	logic r_txb = 1, r_rxr = 0, r_wake = 0, r_clk = 0, r_sync = 0, r_aout = 0;
	logic bt_need = 0, wl_need = 0, ds_req = 0, sl_en = 0, sl_src = 0;
	logic h_txb = 1, h_rxr = 0, h_wake = 0, h_clk = 0, h_sync = 0, h_aout = 0;
	logic r_rxb, r_perm, r_3w, r_dws, r_crx, r_srx, r_ain, r_grant, r_aon;
	logic h_rxb, h_perm, h_rws, h_crx, h_srx, h_ain, h_creq;
	bap_pins_if bap_pins_if_i ();
	bap_radio_end #(.SLEEP_TIMEOUT_CYC(40)) bap_radio_end_i (.clk_sys, .sys_rst,
		.pins(bap_pins_if_i), .route_wr, .route_wr_val(route_val), .audio_role(r_role),
		.uart_tx_bit(r_txb), .uart_rx_ready(r_rxr), .uart_rx_bit(r_rxb), .uart_tx_permit(r_perm),
		.three_wire_mode(r_3w), .route_now(r_route), .host_wake_req(r_wake), .dev_wake_seen(r_dws),
		.audio_clk_src(r_clk), .audio_sync_src(r_sync), .audio_out_bit(r_aout),
		.audio_clk_rx(r_crx), .audio_sync_rx(r_srx), .audio_in_bit(r_ain), .bt_clk_need(bt_need),
		.wlan_clk_need(wl_need), .deep_sleep_req(ds_req), .deep_sleep_grant(r_grant),
		.low_energy_always_on(r_aon));
	bap_host_end bap_host_end_i (.clk_sys, .sys_rst, .pins(bap_pins_if_i), .route_sel(h_route),
		.radio_role(h_role), .uart_tx_bit(h_txb), .uart_rx_ready(h_rxr), .uart_rx_bit(h_rxb),
		.uart_tx_permit(h_perm), .radio_wake_req(h_wake), .radio_wake_seen(h_rws),
		.audio_clk_src(h_clk), .audio_sync_src(h_sync), .audio_out_bit(h_aout),
		.audio_clk_rx(h_crx), .audio_sync_rx(h_srx), .audio_in_bit(h_ain),
		.sleep_clk_en(sl_en), .sleep_clk_src(sl_src), .clk_request_seen(h_creq));
	bap_pins_chk bap_pins_chk_i (.clk_sys, .sys_rst,
		.serial_transmit_line(bap_pins_if_i.serial_transmit_line),
		.clk_request(bap_pins_if_i.clk_request), .audio_serial_out(bap_pins_if_i.audio_serial_out),
		.cts_dev_oe(bap_pins_if_i.cts_dev_oe), .cts_host_oe(bap_pins_if_i.cts_host_oe),
		.rts_dev_o(bap_pins_if_i.rts_dev_o), .rts_dev_oe(bap_pins_if_i.rts_dev_oe),
		.rts_host_oe(bap_pins_if_i.rts_host_oe), .hwake_dev_oe(bap_pins_if_i.hwake_dev_oe),
		.hwake_host_oe(bap_pins_if_i.hwake_host_oe), .aclk_dev_oe(bap_pins_if_i.aclk_dev_oe),
		.async_dev_oe(bap_pins_if_i.async_dev_oe));
	initial forever #10 clk_sys = ~clk_sys;
	always @(posedge clk_sys) begin
		cyc++;
		if (cyc == 3000) begin
			err_count++;
			close_out();
		end
	end
	// ==========================================
	// helpers
	task automatic step(input int n);
		repeat (n) @(negedge clk_sys);
	endtask
	task automatic close_out();
		$display("comparisons %0d mismatches %0d", cmp_count, err_count);
		if (err_count == 0 && cmp_count > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask
	// ==========================================
	// scenarios
	task automatic t_reset();
		`CHK(r_route, BAP_ROUTE_DEFAULT)
		`CHK(r_3w, 1'b0)
		`CHK(bap_pins_if_i.serial_transmit_line, 1'b1)
		`CHK(r_aon, 1'b1)
		$display("test reset done");
	endtask
	task automatic t_link();
		logic v;
		for (int i = 0; i < 2; i++) begin
			v = i[0];
			{r_rxr, h_rxr, r_txb, h_txb, r_wake, h_wake} = {6{v}};
			step(6);
			`CHK(bap_pins_if_i.serial_request_to_send_low, ~v)
			`CHK(h_perm, v)
			`CHK(bap_pins_if_i.serial_clear_to_send_low, ~v)
			`CHK(r_perm, v)
			`CHK({h_rxb, r_rxb, h_rws, r_dws}, {4{v}})
		end
		$display("test link done");
	endtask
	task automatic t_clkreq();
		for (int i = 0; i < 4; i++) begin
			{bt_need, wl_need} = i[1:0];
			step(6);
			`CHK({bap_pins_if_i.clk_request, h_creq}, {2{|i[1:0]}})
		end
		$display("test clock request done");
	endtask
	task automatic set_route(input bap_route_t r);
		route_val = r;
		route_wr = 1'b1;
		step(1);
		route_wr = 1'b0;
		// host follows one cycle late so both ends swap pin drive on one edge
		h_route = r;
		`CHK(r_route, r)
		step(1);
		`CHK(r_3w, r == BAP_ROUTE_AUDIO)
		step(6);
	endtask
	task automatic t_audio(input logic alt);
		logic v, m, pc, ps, po;
		for (int i = 0; i < 4; i++) begin
			{m, v} = i[1:0];
			r_role = bap_audio_role_t'(m);
			h_role = bap_audio_role_t'(m);
			{r_clk, r_sync, r_aout} = {3{v}};
			{h_clk, h_sync, h_aout} = {3{~v}};
			step(8);
			pc = alt ? bap_pins_if_i.serial_request_to_send_low : bap_pins_if_i.audio_bit_clock;
			ps = alt ? bap_pins_if_i.radio_to_host_wake : bap_pins_if_i.audio_frame_sync;
			po = alt ? bap_pins_if_i.serial_clear_to_send_low : bap_pins_if_i.audio_serial_out;
			`CHK(pc, m ? v : ~v)
			`CHK(ps, m ? v : ~v)
			`CHK({r_crx, h_crx, r_srx, h_srx}, {4{m ? v : ~v}})
			`CHK(po, v)
			`CHK({h_ain, r_ain}, {v, ~v})
		end
		$display("test audio done");
	endtask
	task automatic t_three_wire();
		{r_rxr, h_rxr, r_wake} = 3'h0;
		set_route(BAP_ROUTE_AUDIO);
		`CHK({r_perm, h_perm, r_dws}, 3'h6)
		r_txb = 1'b0;
		h_txb = 1'b0;
		step(6);
		`CHK({h_rxb, r_rxb}, 2'h0)
		t_audio(1'b1);
		r_role = BAP_AUDIO_MASTER;
		h_role = BAP_AUDIO_MASTER;
		step(4);
		set_route(BAP_ROUTE_DEFAULT);
		`CHK({r_perm, h_perm}, 2'h0)
		$display("test three wire done");
	endtask
	task automatic t_sleep();
		ds_req = 1'b1;
		step(60);
		`CHK({r_aon, r_grant}, 2'h2)
		sl_en = 1'b1;
		// period of 10 cycles keeps well inside the shortened timeout
		repeat (8) begin
			sl_src = ~sl_src;
			step(5);
		end
		`CHK({r_aon, r_grant}, 2'h1)
		sl_en = 1'b0;
		step(60);
		`CHK({r_aon, r_grant}, 2'h2)
		$display("test sleep clock done");
	endtask
	initial begin
		step(4);
		sys_rst = 1'b0;
		step(1);
		t_reset();
		t_link();
		t_clkreq();
		t_audio(1'b0);
		t_three_wire();
		t_sleep();
		close_out();
	end
endmodule
